// ==== core/tcss_pkg.sv ====
package tcss_pkg;
  // Selection codes
  localparam logic [2:0] SEL_24M     = 3'h1;
  localparam logic [2:0] SEL_12M     = 3'h2;
  localparam logic [2:0] SEL_6M      = 3'h3;
  localparam logic [2:0] SEL_3M      = 3'h4;
  localparam logic [2:0] SEL_1M5     = 3'h5;
  localparam logic [2:0] SEL_750K    = 3'h6;
  localparam logic [2:0] SEL_DEFAULT = SEL_6M;
  // Base clock is 48 MHz, so a half period of 1 tick gives 24 MHz
  localparam int         BASE_MHZ    = 48;
  localparam int         CNT_W       = 6;
  localparam logic [5:0] HALF_MIN    = 6'h01;
  localparam int         SEL_SHIFT_BASE = 1;
  // Speed indication
  localparam logic       SPEED_FS    = 1'b0;
  localparam logic       SPEED_HS    = 1'b1;
endpackage

// ==== core/tcss_clock_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcss_clock_select #(
  parameter int SEL_W    = 3,
  parameter int CNT_W    = tcss_pkg::CNT_W,
  parameter int SYNC_LEN = 2
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Selection from host command path
  input  wire logic [SEL_W-1:0] sel_code,
  input  wire logic             sel_load,
  input  wire logic             xfer_busy,
  input  wire logic             clk_run,
  // USB attach status, asynchronous pins
  input  wire logic             host_hs_capable,
  input  wire logic             enum_done,
  // Target clock and status
  output logic                  target_serial_clock,
  output logic [SEL_W-1:0]      active_sel,
  output logic                  usb_speed,
  output logic                  status_led_en
);

  // Constants
  localparam int               SYNC_N    = 2;
  localparam int               SYNC_HS   = 0;
  localparam int               SYNC_ENUM = 1;
  localparam int               SEL_N     = 1 << SEL_W;
  localparam logic [CNT_W-1:0] CNT_CLR   = '0;
  localparam logic [CNT_W-1:0] CNT_STEP  = CNT_W'(tcss_pkg::HALF_MIN);
  localparam logic [SEL_W-1:0] SEL_RST   = SEL_W'(tcss_pkg::SEL_DEFAULT);
  localparam logic [SEL_W-1:0] SEL_LO    = SEL_W'(tcss_pkg::SEL_24M);
  localparam logic [SEL_W-1:0] SEL_HI    = SEL_W'(tcss_pkg::SEL_750K);
  localparam logic [SEL_W-1:0] SEL_BASE  = SEL_W'(tcss_pkg::SEL_SHIFT_BASE);

  // Selection state
  logic [SEL_W-1:0]  pend_r;
  logic [SEL_W-1:0]  pend_nxt;
  logic              pend_v_r;
  logic              pend_v_nxt;
  logic [SEL_W-1:0]  act_r;
  logic [SEL_W-1:0]  act_nxt;

  // Divider state
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              tclk_r;
  logic              tclk_nxt;

  // Attach status
  logic [SYNC_N-1:0] async_pins;
  logic [SYNC_N-1:0] pins_sync;
  logic              speed_r;
  logic              speed_nxt;
  logic              led_r;
  logic              led_nxt;

  // Decode
  wire  [CNT_W-1:0]  half_tbl [0:SEL_N-1];
  logic [CNT_W-1:0]  half_cnt;
  logic              sel_ge_lo;
  logic              sel_le_hi;
  logic              sel_ok;
  logic              load_ok;
  logic              half_done;
  logic              at_low;
  logic              swap_window;
  logic              may_swap;
  logic              toggle;
  logic              cnt_clr;

  // Selection decode
  assign sel_ge_lo = (sel_code >= SEL_LO);
  assign sel_le_hi = (sel_code <= SEL_HI);
  assign sel_ok    = sel_ge_lo && sel_le_hi;
  assign load_ok   = sel_load && sel_ok;

  // Half period per selection code: 1 << (code - 1) reference ticks
  generate
    for (genvar s = 0; s < SEL_N; s++) begin : g_half
      if (s >= SEL_LO && s <= SEL_HI) begin : g_valid
        assign half_tbl[s] = CNT_STEP << (s - SEL_BASE);
      end else begin : g_hold
        assign half_tbl[s] = CNT_STEP;
      end
    end
  endgenerate

  assign half_cnt  = half_tbl[act_r];
  assign half_done = (cnt_r == half_cnt - CNT_STEP);

  // Safe point for a swap: idle link, end of a low half or stopped clock
  assign at_low      = !tclk_r;
  assign swap_window = half_done || !clk_run;
  assign may_swap    = pend_v_r &&
                       !xfer_busy &&
                       at_low &&
                       swap_window;
  assign toggle      = clk_run && half_done;
  assign cnt_clr     = may_swap || half_done || !clk_run;

  // Next values
  assign pend_nxt   = load_ok ? sel_code : pend_r;
  assign pend_v_nxt = load_ok  ? 1'b1 :
                      may_swap ? 1'b0 :
                      pend_v_r;
  assign act_nxt    = may_swap ? pend_r : act_r;
  assign cnt_nxt    = cnt_clr ? CNT_CLR :
                      cnt_r + CNT_STEP;
  assign tclk_nxt   = !clk_run               ? 1'b0 :
                      (toggle && !may_swap)  ? !tclk_r :
                      tclk_r;
  assign speed_nxt  = pins_sync[SYNC_HS] ? tcss_pkg::SPEED_HS :
                      tcss_pkg::SPEED_FS;
  assign led_nxt    = pins_sync[SYNC_ENUM];

  // Pending selection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= SEL_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Pending flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_v_r <= 1'b0;
    end else begin
      pend_v_r <= pend_v_nxt;
    end
  end

  // Selection in force
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= SEL_RST;
    end else begin
      act_r <= act_nxt;
    end
  end

  // Divider count, restarted on swap so no runt phase appears
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_CLR;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Target clock level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tclk_r <= 1'b0;
    end else begin
      tclk_r <= tclk_nxt;
    end
  end

  // Attach pin synchronisers
  assign async_pins[SYNC_HS]   = host_hs_capable;
  assign async_pins[SYNC_ENUM] = enum_done;

  generate
    for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
      logic [SYNC_LEN-1:0] stage_r;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_r <= '0;
        end else begin
          stage_r <= {stage_r[SYNC_LEN-2:0], async_pins[g]};
        end
      end
      assign pins_sync[g] = stage_r[SYNC_LEN-1];
    end
  endgenerate

  // Link speed indication
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_r <= tcss_pkg::SPEED_FS;
    end else begin
      speed_r <= speed_nxt;
    end
  end

  // Status indicator, dark until enumeration completes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_r <= 1'b0;
    end else begin
      led_r <= led_nxt;
    end
  end

  // Outputs
  assign target_serial_clock = tclk_r;
  assign active_sel          = act_r;
  assign usb_speed           = speed_r;
  assign status_led_en       = led_r;

endmodule
`default_nettype wire

// ==== bench/tcss_clock_select_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcss_clock_select_sva (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Watched inputs
  input wire logic       xfer_busy,
  input wire logic       host_hs_capable,
  input wire logic       enum_done,
  // Watched outputs
  input wire logic       target_serial_clock,
  input wire logic       usb_speed,
  input wire logic       status_led_en,
  input wire logic [2:0] active_sel
);
  wire c = target_serial_clock;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_reset_sel: assert property ($rose(rst_n)|->active_sel==3'h3) else $error("rst");
  a_sel_legal: assert property (active_sel inside {[3'h1:3'h6]}) else $error("sel");
  a_busy_hold: assert property (xfer_busy|=>$stable(active_sel)) else $error("busy");
  a_swap_low: assert property ($changed(active_sel)|->!$past(c)) else $error("swap");
  a_half_fast: assert property ($rose(c)&&active_sel==3'h1|=>!c) else $error("fast");
  a_half_mid: assert property ($rose(c)&&active_sel==3'h2|=>c##1!c) else $error("mid");
  a_led_dark: assert property (!enum_done[*4]|->!status_led_en) else $error("led");
  a_speed_hs: assert property (host_hs_capable[*5]|->usb_speed) else $error("hs");
  c_swap: cover property ($changed(active_sel));
  c_led: cover property ($rose(status_led_en));
  c_busy: cover property (xfer_busy##1!xfer_busy);
endmodule
bind tcss_clock_select tcss_clock_select_sva tcss_clock_select_sva_inst (.*);
`default_nettype wire

// ==== bench/tcss_target_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcss_target_model (
  input  wire logic target_serial_clock,
  output int        edges
);
  initial edges = 0;
  always @(posedge target_serial_clock) edges <= edges + 1;
endmodule
`default_nettype wire

// ==== bench/target_clock_speed_select_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module target_clock_speed_select_bench;
  logic c=0,rst_n=0,ld=0,bz=0,run=0,hs=0,en=0;
  logic [2:0] cd=3'h3;
  wire logic k,sp,led;
  wire logic [2:0] a;
  int edges,errors=0,compares=0,m=3,o,n;
  tcss_clock_select tcss_clock_select_inst(.ref_clk(c),.rst_n(rst_n),.sel_code(cd),.sel_load(ld),
    .xfer_busy(bz),.clk_run(run),.host_hs_capable(hs),.enum_done(en),.target_serial_clock(k),
    .active_sel(a),.usb_speed(sp),.status_led_en(led));
  tcss_target_model tcss_target_model_inst(.target_serial_clock(k),.edges(edges));
  initial forever #12.5 c=~c;
  task w(int t); repeat(t) @(posedge c); #1; endtask
  task chk(logic [7:0] s,e,string t); compares++;
    if(s!==e) begin errors++; $display("wrong value %s exp %0h seen %0h",t,e,s); end
  endtask
  task finish_test; $display("compares %0d errors %0d",compares,errors);
    if(errors==0&&compares>0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin #300us; errors++; finish_test; end
  initial begin
    void'($urandom(32'hEB96)); w(20); rst_n=1; w(1);
    chk(8'(a),8'h3,"reset");
    for(int i=0;i<8;i++) begin
      run=0; ld=1; cd=3'(i); w(1); ld=0; w(3); m=(i>0&&i<7)?i:m;
      chk(8'(a),8'(m),"sel"); run=1; n=0;
      while(k!==1'b1&&n<99) begin w(1); n++; end
      for(n=0;k===1'b1&&n<99;n++) w(1);
      chk(8'(n),8'(1<<(m-1)),"half");
    end
    $display("select test done");
    bz=1; o=m; m=$urandom_range(1,5); ld=1; cd=3'(m); w(1); ld=0; w(70);
    chk(8'(a),8'(o),"busy"); bz=0; w(70); chk(8'(a),8'(m),"swap");
    hs=1'($urandom); w(6); chk(8'(led),8'h0,"dark"); chk(8'(edges>0),8'h1,"edges");
    en=1; w(5); chk(8'(led),8'h1,"led"); chk(8'(sp),8'(hs),"speed");
    $display("usb test done"); finish_test;
  end
endmodule
`default_nettype wire
